// [cfg_port_map.svh]
// Purpose: Offsets, field positions, reset values and timing figures of the load port.
// Assumes: APB byte addresses, 32-bit words, 25 ns core clock.
// Notes:   Definitions only.
`ifndef CFG_PORT_MAP_SVH
`define CFG_PORT_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTRL_OFFSET        12'h000
`define LENGTH_OFFSET      12'h004
`define STATUS_OFFSET      12'h008
`define COUNT_OFFSET       12'h00C
`define LAST_DATA_OFFSET   12'h010
`define USER_OUT_OFFSET    12'h014

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_FIELD_BITS    7
`define STATUS_STATE_LSB   0
`define STATUS_ERROR_BIT   3
`define STATUS_USER_BIT    4
`define STATUS_REQ_BIT     5
`define STATUS_RATIO_LSB   8
`define CTRL_RESET         7'h00
`define LENGTH_RESET       32'h0000_0100
`define USER_OUT_RESET     32'h0000_0000

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS    25
`define REQ_TO_LOW_MAX_NS  600
`define STATUS_LOW_MIN_US  268
`define STATUS_LOW_MAX_US  1506
`define POR_DELAY_US       300
`define INIT_MIN_US        175
`define CFG_CLOCK_MAX_NS   10
`define USER_CLK_EN_PERIODS 4
`define USER_INIT_EDGES    8576
`define INIT_FALL_EDGES    2

`endif

// [cfg_port_pkg.sv]
// Purpose: Types shared by the load port modules.
// Assumes: Nothing beyond the map header.
// Notes:   States follow a Gray path from power-on to user mode.
package cfg_port_pkg;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_HOLD  = 3'h1,
    ST_LOAD  = 3'h3,
    ST_FLUSH = 3'h2,
    ST_START = 3'h6,
    ST_INIT  = 3'h7,
    ST_USER  = 3'h5
  } cfg_state_type;

  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } bus_width_type;

  typedef struct packed {
    logic          data_drive;
    logic          init_done_en;
    logic          user_clock_opt;
    logic          security;
    logic          decompress;
    bus_width_type width;
  } ctrl_type;

endpackage : cfg_port_pkg

// [cfg_sync2.sv]
// Purpose: Two-stage synchroniser for a group of pins.
// Assumes: Inputs are asynchronous to the clock.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module cfg_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : cfg_sync2

// [cfg_delay_timer.sv]
// Purpose: Loadable down counter that flags when a delay has run out.
// Assumes: Load has priority over counting.
// Notes:   The count starts from RESET_COUNT after reset.
`timescale 1ns/1ps
module cfg_delay_timer #(
  parameter int               WIDTH       = 17,
  parameter logic [WIDTH-1:0] RESET_COUNT = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired
);

  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count_reg <= RESET_COUNT;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = (count_reg == '0);

endmodule : cfg_delay_timer

// [cfg_parallel_port.sv]
// Purpose: Fast parallel configuration load port with APB control and status.
// Assumes: Pins are asynchronous and pass two flip-flops; open-drain pins are resolved outside.
// Notes:   Control bits must be set before the load starts.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "cfg_port_map.svh"

// Operation
// - Clock-per-word ratio follows width, decompression and security settings.
// - 8-bit mode uses bits 7..0, 16-bit mode bits 15..0.
// - In user mode request, status and complete are all high.
// - Status is held low for the power-on delay.
// - Complete stays low after power-up and during loading.
// - Complete is released only after all words arrive without error.
// - After completion two falling clock edges start initialization; then the configuration clock is ignored.
// - Init-done output is driven low until initialization ends, if enabled.
// - Data pins become user I/O after configuration.
// - Complete falls within 600 ns of the request falling.
// - Status falls within 600 ns of the request falling.
// - Status low pulse lasts between 268 and 1506 us.
// - Status rises within 1506 us of the request rising.
// - With the internal clock, user mode follows after the init delay.
// - With the user clock, wait four clock periods then 8576 user edges.
module cfg_parallel_port
  import cfg_port_pkg::*;
#(
  parameter int POR_CYCLES        = (`POR_DELAY_US * 1000) / `CLOCK_PERIOD_NS,
  parameter int STATUS_LOW_CYCLES =
    (`STATUS_LOW_MIN_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS,
  parameter int INIT_CYCLES       =
    (`INIT_MIN_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS,
  parameter int USER_INIT_EDGES   = `USER_INIT_EDGES
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Configuration request and status
  input  wire logic        CONFIG_REQ_B,
  input  wire logic        STATUS_B_IN,
  output logic             STATUS_B_OUT,
  output logic             STATUS_B_OE_B,
  output logic             CFG_COMPLETE_OUT,
  output logic             CFG_COMPLETE_OE_B,
  // Clocks from the host
  input  wire logic        CFG_CLOCK,
  input  wire logic        USER_INIT_CLOCK,
  // Data pins
  input  wire logic [31:0] DATA_IN,
  output logic      [31:0] DATA_OUT,
  output logic             DATA_OE_B,
  // Initialization
  output logic             INIT_DONE_OUT,
  output logic             INIT_DONE_OE_B,
  output logic             USER_MODE
);

  // ----------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------
  localparam int TW               = 17;
  localparam int REQ_LOW_MAX_CYC  = `REQ_TO_LOW_MAX_NS / `CLOCK_PERIOD_NS;
  localparam int STATUS_MAX_CYC   = (`STATUS_LOW_MAX_US * 1000) / `CLOCK_PERIOD_NS;
  localparam int USER_EN_CYC      =
    (`USER_CLK_EN_PERIODS * `CFG_CLOCK_MAX_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;

  function automatic logic [3:0] clock_ratio(input ctrl_type c);
    case (c.width)
      WIDTH_8:  clock_ratio = c.decompress ? 4'h2 : 4'h1;
      WIDTH_16: clock_ratio = c.decompress ? 4'h4 : (c.security ? 4'h2 : 4'h1);
      WIDTH_32: clock_ratio = c.decompress ? 4'h8 : (c.security ? 4'h4 : 4'h1);
      default:  clock_ratio = 4'h1;
    endcase
  endfunction : clock_ratio

  function automatic logic [31:0] width_mask(input bus_width_type w);
    case (w)
      WIDTH_8:  width_mask = 32'h0000_00FF;
      WIDTH_16: width_mask = 32'h0000_FFFF;
      default:  width_mask = 32'hFFFF_FFFF;
    endcase
  endfunction : width_mask

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [35:0] sync_bus;
  logic        req_s;
  logic        status_s;
  logic        clk_s;
  logic        uclk_s;
  logic [31:0] data_s;
  logic        clk_prev_reg;
  logic        uclk_prev_reg;

  cfg_sync2 #(.WIDTH(36)) pin_sync (
    .clock    (CLOCK),
    .rst_b    (RST_B),
    .async_in ({CONFIG_REQ_B, STATUS_B_IN, CFG_CLOCK, USER_INIT_CLOCK, DATA_IN}),
    .sync_out (sync_bus)
  );

  assign req_s    = sync_bus[35];
  assign status_s = sync_bus[34];
  assign clk_s    = sync_bus[33];
  assign uclk_s   = sync_bus[32];
  assign data_s   = sync_bus[31:0];

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      clk_prev_reg  <= 1'b0;
      uclk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg  <= clk_s;
      uclk_prev_reg <= uclk_s;
    end
  end

  wire cfg_rise  = clk_s & ~clk_prev_reg;
  wire cfg_fall  = ~clk_s & clk_prev_reg;
  wire uclk_rise = uclk_s & ~uclk_prev_reg;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  ctrl_type      ctrl_reg;
  logic [31:0]   length_reg;
  logic [31:0]   user_out_reg;
  cfg_state_type state_reg;
  cfg_state_type state_next;
  logic [3:0]    phase_reg;
  logic [31:0]   word_count_reg;
  logic [31:0]   last_data_reg;
  logic          error_reg;
  logic [1:0]    fall_count_reg;
  logic [13:0]   user_edges_reg;
  logic          timer_expired;
  logic          status_oe_b_reg;
  logic          complete_oe_b_reg;
  logic          init_done_oe_b_reg;
  logic          data_oe_b_reg;
  logic          user_mode_reg;

  // ----------------------------------------------------------------
  // Load path decoding
  // ----------------------------------------------------------------
  wire [3:0] ratio      = clock_ratio(ctrl_reg);
  wire       width_bad  = (ctrl_reg.width != WIDTH_8) && (ctrl_reg.width != WIDTH_16)
                          && (ctrl_reg.width != WIDTH_32);
  wire       clock_ok   = cfg_rise && status_s;
  wire       phase_wrap = (phase_reg == (ratio - 4'h1));
  wire       capture    = (state_reg == ST_LOAD) && clock_ok && (phase_reg == 4'h0);
  wire       last_word  = capture && ((word_count_reg + 32'h1) == length_reg);
  wire       load_ok    = last_word && !error_reg && !width_bad;
  wire       user_done  = (user_edges_reg == 14'(USER_INIT_EDGES));
  wire       enter_hold = (state_next == ST_HOLD) && (state_reg != ST_HOLD);
  wire       error_set  = capture && width_bad;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: begin
        if (timer_expired) begin
          state_next = req_s ? ST_LOAD : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (req_s && timer_expired) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_ok) begin
          state_next = (ratio == 4'h1) ? ST_START : ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (clock_ok && phase_wrap) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (cfg_fall && (fall_count_reg == 2'(`INIT_FALL_EDGES - 1))) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (timer_expired && (!ctrl_reg.user_clock_opt || user_done)) begin
          state_next = ST_USER;
        end
      end
      ST_USER: begin
        state_next = ST_USER;
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
    if (!req_s && (state_reg != ST_POR)) begin
      state_next = ST_HOLD;
    end
  end

  // Delay timer reload on entry to a timed state.
  wire          timer_load  = enter_hold || ((state_next == ST_INIT) && (state_reg != ST_INIT));
  wire [TW-1:0] timer_value = (state_next == ST_HOLD) ? TW'(STATUS_LOW_CYCLES) :
                              ctrl_reg.user_clock_opt ? TW'(USER_EN_CYC) :
                              TW'(INIT_CYCLES);

  cfg_delay_timer #(.WIDTH(TW), .RESET_COUNT(TW'(POR_CYCLES))) delay_timer (
    .clock      (CLOCK),
    .rst_b      (RST_B),
    .load       (timer_load),
    .load_value (timer_value),
    .expired    (timer_expired)
  );

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B || enter_hold) begin
      phase_reg      <= 4'h0;
      word_count_reg <= 32'h0;
    end else if (clock_ok && ((state_reg == ST_LOAD) || (state_reg == ST_FLUSH))) begin
      phase_reg      <= phase_wrap ? 4'h0 : (phase_reg + 4'h1);
      word_count_reg <= capture ? (word_count_reg + 32'h1) : word_count_reg;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      last_data_reg <= 32'h0;
    end else if (capture) begin
      last_data_reg <= data_s & width_mask(ctrl_reg.width);
    end
  end

  // An error seen in the same cycle as the clear is kept.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      error_reg <= 1'b0;
    end else if (error_set) begin
      error_reg <= 1'b1;
    end else if (enter_hold) begin
      error_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B || (state_reg != ST_START)) begin
      fall_count_reg <= 2'h0;
    end else if (cfg_fall) begin
      fall_count_reg <= fall_count_reg + 2'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B || (state_reg != ST_INIT)) begin
      user_edges_reg <= 14'h0;
    end else if (timer_expired && uclk_rise && !user_done) begin
      user_edges_reg <= user_edges_reg + 14'h1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  wire status_drive   = (state_next == ST_POR) || (state_next == ST_HOLD) ||
                        error_reg || error_set;
  wire complete_drive = (state_next == ST_POR) || (state_next == ST_HOLD) ||
                        (state_next == ST_LOAD) || (state_next == ST_FLUSH);
  wire init_drive     = ctrl_reg.init_done_en &&
                        ((state_next == ST_START) || (state_next == ST_INIT));
  wire data_drive     = (state_next == ST_USER) && ctrl_reg.data_drive;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      status_oe_b_reg    <= 1'b0;
      complete_oe_b_reg  <= 1'b0;
      init_done_oe_b_reg <= 1'b1;
      data_oe_b_reg      <= 1'b1;
      user_mode_reg      <= 1'b0;
    end else begin
      status_oe_b_reg    <= !status_drive;
      complete_oe_b_reg  <= !complete_drive;
      init_done_oe_b_reg <= !init_drive;
      data_oe_b_reg      <= !data_drive;
      user_mode_reg      <= (state_next == ST_USER);
    end
  end

  assign STATUS_B_OUT      = 1'b0;
  assign STATUS_B_OE_B     = status_oe_b_reg;
  assign CFG_COMPLETE_OUT  = 1'b0;
  assign CFG_COMPLETE_OE_B = complete_oe_b_reg;
  assign INIT_DONE_OUT     = 1'b0;
  assign INIT_DONE_OE_B    = init_done_oe_b_reg;
  assign DATA_OUT          = user_out_reg;
  assign DATA_OE_B         = data_oe_b_reg;
  assign USER_MODE         = user_mode_reg;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  wire sel_ctrl   = (PADDR == `CTRL_OFFSET);
  wire sel_length = (PADDR == `LENGTH_OFFSET);
  wire sel_status = (PADDR == `STATUS_OFFSET);
  wire sel_count  = (PADDR == `COUNT_OFFSET);
  wire sel_last   = (PADDR == `LAST_DATA_OFFSET);
  wire sel_user   = (PADDR == `USER_OUT_OFFSET);
  wire mapped     = sel_ctrl | sel_length | sel_status | sel_count | sel_last | sel_user;
  wire apb_setup  = PSEL && !PENABLE;
  wire apb_write  = PSEL && PENABLE && PWRITE;

  wire [31:0] status_word = {20'h0, ratio, 2'h0, req_s, user_mode_reg, error_reg, state_reg};
  wire [31:0] read_mux    = sel_ctrl   ? {25'h0, ctrl_reg} :
                            sel_length ? length_reg :
                            sel_status ? status_word :
                            sel_count  ? word_count_reg :
                            sel_last   ? last_data_reg :
                            sel_user   ? user_out_reg : 32'h0;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ctrl_reg     <= ctrl_type'(`CTRL_RESET);
      length_reg   <= `LENGTH_RESET;
      user_out_reg <= `USER_OUT_RESET;
    end else if (apb_write) begin
      ctrl_reg     <= sel_ctrl ? ctrl_type'(PWDATA[`CTRL_FIELD_BITS-1:0]) : ctrl_reg;
      length_reg   <= sel_length ? PWDATA : length_reg;
      user_out_reg <= sel_user ? PWDATA : user_out_reg;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= PWRITE ? 32'h0 : read_mux;
      pslverr_reg <= !mapped;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = pslverr_reg & PSEL & PENABLE;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [TW-1:0] low_cnt_reg;
  logic [TW-1:0] rel_cnt_reg;
  logic [TW-1:0] init_cnt_reg;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      low_cnt_reg  <= '0;
      rel_cnt_reg  <= '0;
      init_cnt_reg <= '0;
    end else begin
      low_cnt_reg  <= STATUS_B_OE_B ? '0 : (low_cnt_reg + TW'(low_cnt_reg != '1));
      rel_cnt_reg  <= (req_s && !STATUS_B_OE_B && !error_reg) ?
                      (rel_cnt_reg + TW'(rel_cnt_reg != '1)) : '0;
      init_cnt_reg <= (state_reg == ST_INIT) ? (init_cnt_reg + TW'(init_cnt_reg != '1)) : '0;
    end
  end

  sequence last_word_s;
    (state_reg == ST_FLUSH) && clock_ok && phase_wrap;
  endsequence

  sequence second_fall_s;
    (state_reg == ST_START) && cfg_fall && (fall_count_reg == 2'h1);
  endsequence

  req_status_low_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(CONFIG_REQ_B) && (state_reg != ST_POR) |-> ##[1:REQ_LOW_MAX_CYC] !STATUS_B_OE_B)
    else $error("Status did not fall after request fell.");

  req_complete_low_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(CONFIG_REQ_B) && (state_reg != ST_POR) |-> ##[1:REQ_LOW_MAX_CYC] !CFG_COMPLETE_OE_B)
    else $error("Complete did not fall after request fell.");

  status_pulse_min_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $rose(STATUS_B_OE_B) && ($past(state_reg, 2) == ST_HOLD)
    |-> (low_cnt_reg >= TW'(STATUS_LOW_CYCLES)))
    else $error("Status low pulse too short.");

  status_release_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    rel_cnt_reg <= TW'(STATUS_MAX_CYC))
    else $error("Status held low too long after request rose.");

  complete_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ((state_reg == ST_LOAD) || (state_reg == ST_FLUSH)) |-> !CFG_COMPLETE_OE_B)
    else $error("Complete released during loading.");

  complete_words_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $rose(CFG_COMPLETE_OE_B) |-> (word_count_reg == length_reg) && !error_reg)
    else $error("Complete released before all words arrived.");

  flush_tail_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    last_word_s ##1 req_s |-> (state_reg == ST_START) ##1 CFG_COMPLETE_OE_B)
    else $error("Flush did not end on the final extra clock.");

  init_start_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    second_fall_s ##1 req_s |-> (state_reg == ST_INIT))
    else $error("Initialization did not start after two falling edges.");

  user_stays_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_reg == ST_USER) && req_s |=> (state_reg == ST_USER) && USER_MODE)
    else $error("User mode left without a request.");

  init_done_low_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_reg == ST_INIT) && $stable(state_reg) && ctrl_reg.init_done_en |-> !INIT_DONE_OE_B)
    else $error("Init-done not driven during initialization.");

  data_release_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !USER_MODE |-> DATA_OE_B)
    else $error("Data pins driven before user mode.");

  init_delay_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_reg == ST_INIT) && (state_next == ST_USER) && !ctrl_reg.user_clock_opt
    |-> (init_cnt_reg >= TW'(INIT_CYCLES - 1)))
    else $error("User mode entered before the initialization delay.");

  flush_phase_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_reg == ST_FLUSH) |-> (phase_reg != 4'h0) && (phase_reg < ratio))
    else $error("Flush phase outside the clock ratio.");

endmodule : cfg_parallel_port

// [cfg_host_model.sv]
// Purpose: Host that drives the load pins of the port.
// Assumes: Link clock high and low at least four core cycles each.
// Notes:   Released data shows the inverse of the last word.
`timescale 1ns/1ps
module cfg_host_model (
  // Core clock
  input  wire logic        clock,
  // Pins
  output logic             req_b,
  output logic             cfg_clk,
  output logic             user_clk,
  output logic      [31:0] data
);
  initial begin
    {req_b, cfg_clk, user_clk, data} = {3'h4, 32'h0};
  end
  always begin
    repeat (4) @(posedge clock);
    user_clk <= ~user_clk;
  end
  task automatic request();
    @(posedge clock) req_b <= 1'b0;
    repeat (80) @(posedge clock);
    req_b <= 1'b1;
  endtask : request
  task automatic rise(input logic [31:0] d);
    @(posedge clock) data <= d;
    repeat (3) @(posedge clock);
    cfg_clk <= 1'b1;
  endtask : rise
  task automatic fall();
    repeat (4) @(posedge clock);
    cfg_clk <= 1'b0;
    data <= ~data;
  endtask : fall
endmodule : cfg_host_model

// [tb_top.sv]
// Purpose: Self-checking bench of the parallel load port.
// Assumes: Shortened delay parameters.
// Notes:   The status wire has a pull-up; complete is read at its enable.
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst_b, psel, penable, pwrite, req_b, cfg_clk, user_clk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, data_in, data_out, rd;
  logic        pready, pslverr, st_out, st_oe_b, cd_out, cd_oe_b, data_oe_b, id_out, id_oe_b;
  logic        user_mode;
  int          fail_count, comparisons;
  wire         status_b = st_oe_b | st_out;
  cfg_parallel_port #(.POR_CYCLES(20), .STATUS_LOW_CYCLES(30),
    .USER_INIT_EDGES(8)) i_cfg_parallel_port (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CONFIG_REQ_B(req_b), .STATUS_B_IN(status_b),
    .STATUS_B_OUT(st_out), .STATUS_B_OE_B(st_oe_b), .CFG_COMPLETE_OUT(cd_out),
    .CFG_COMPLETE_OE_B(cd_oe_b), .CFG_CLOCK(cfg_clk), .USER_INIT_CLOCK(user_clk),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_B(data_oe_b), .INIT_DONE_OUT(id_out),
    .INIT_DONE_OE_B(id_oe_b), .USER_MODE(user_mode));
  cfg_host_model i_cfg_host_model (.clock(clock), .req_b(req_b), .cfg_clk(cfg_clk),
    .user_clk(user_clk), .data(data_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask : apb
  // Polls at the falling edge so that register updates have landed.
  task automatic await(input int s);
    logic [2:0] v;
    for (int k = 0; k < 8000; k++) begin
      @(negedge clock);
      v = {user_mode, cd_oe_b, st_oe_b};
      if (v[s] === 1'b1) break;
    end
  endtask : await
  function automatic logic [3:0] ratio(input logic [1:0] w, input logic d, input logic s);
    return w == 2'h0 ? (d ? 4'h2 : 4'h1) : w == 2'h1 ? (d ? 4'h4 : s ? 4'h2 : 4'h1)
         : (d ? 4'h8 : s ? 4'h4 : 4'h1);
  endfunction : ratio
  task automatic run(input logic [6:0] c, input int n);
    int r;
    logic [31:0] m;
    r = ratio(c[1:0], c[2], c[3]);
    m = c[1:0] == 2'h0 ? 32'hFF : c[1:0] == 2'h1 ? 32'hFFFF : 32'hFFFF_FFFF;
    apb(1'b1, 12'h000, {25'h0, c});
    apb(1'b1, 12'h004, n);
    apb(1'b1, 12'h014, 32'h5A5A_0F0F);
    fork
      i_cfg_host_model.request();
      begin repeat (24) @(negedge clock); chk({30'h0, st_oe_b, cd_oe_b}, 0); end
    join
    await(0);
    chk({31'h0, st_oe_b}, 1);
    repeat (80) @(posedge clock);
    for (int k = 0; k < n * r; k++) begin
      if (k == n * r - 1) chk({31'h0, cd_oe_b}, 0);
      i_cfg_host_model.rise(32'hFEDC_BA98 ^ k);
      if (k < n * r - 1) i_cfg_host_model.fall();
    end
    await(1);
    chk({31'h0, cd_oe_b}, 1);
    apb(1'b0, 12'h010, 0);
    chk(rd, (32'hFEDC_BA98 ^ ((n - 1) * r)) & m);
    apb(1'b0, 12'h00C, 0);
    chk(rd, n);
    i_cfg_host_model.fall();
    i_cfg_host_model.rise(0);
    i_cfg_host_model.fall();
    repeat (6) @(negedge clock);
    chk({30'h0, user_mode, id_oe_b}, {31'h0, ~c[5]});
    await(2);
    chk({27'h0, user_mode, st_oe_b, cd_oe_b, id_oe_b, data_oe_b}, {27'h0, 4'hF, ~c[6]});
    chk(data_out, 32'h5A5A_0F0F);
    i_cfg_host_model.rise(0);
    i_cfg_host_model.fall();
    apb(1'b0, 12'h00C, 0);
    chk(rd, n);
  endtask : run
  task automatic summarize();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, fail_count, comparisons} = '0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk({30'h0, st_oe_b, cd_oe_b}, 0);
    chk({29'h0, st_out, cd_out, id_out}, 0);
    apb(1'b0, 12'h004, 0);
    chk(rd, 32'h100);
    apb(1'b0, 12'h040, 0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, 12'h000, {28'h0, i[1], i[0], i[3:2]});
      apb(1'b0, 12'h008, 0);
      chk({28'h0, rd[11:8]}, {28'h0, ratio(i[3:2], i[0], i[1])});
    end
    run(7'h65, 2);
    run(7'h10, 1);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    summarize();
  end
endmodule : tb_top
